// File: design/irq_seq_pkg.sv
// Constants, register map and carrier types for the peripheral interrupt sequencer
package irq_seq_pkg;
  localparam int NUM_FLAGS = 11;
  localparam int NUM_VECTORS = 8;
  localparam int VEC_W = 3;
  localparam int PC_W = 13;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Request flag positions; positions below F_SHARED are also vector indices
  localparam int F_SERIAL = 0;
  localparam int F_LV = 1;
  localparam int F_EEPROM = 2;
  localparam int F_T0A = 3;
  localparam int F_T0P = 4;
  localparam int F_PTA = 5;
  localparam int F_PTP = 6;
  localparam int F_SHARED = 7;
  localparam int F_UART = 8;
  localparam int F_T1A = 9;
  localparam int F_T1P = 10;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

  // Control register fields
  localparam int CTRL_GLOBAL_BIT = 0;
  localparam int CTRL_SHARED_BIT = 1;
  // Status register fields
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_WAKE_BIT = 4;

  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 11'h000;
  localparam logic [NUM_FLAGS-1:0] ENABLE_RESET = 11'h000;
  localparam logic [VEC_W-1:0] VEC_RESET = 3'h0;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

  typedef struct packed {
    logic rx_done;
    logic tx_done;
    logic i2c_addr_match;
    logic i2c_timeout;
  } serial_events_t;

  typedef struct packed {
    logic tx_empty;
    logic tx_idle;
    logic rx_avail;
    logic rx_overrun;
    logic addr_detect;
    logic rx_wake;
  } uart_events_t;

  typedef struct packed {
    logic t0_match_a;
    logic t0_match_p;
    logic t1_match_a;
    logic t1_match_p;
    logic pt_match_a;
    logic pt_match_p;
  } timer_events_t;

  typedef struct packed {
    logic stack_full;
    logic return_from_interrupt_op;
    logic plain_return_op;
    logic sleep_mode;
  } core_ctl_t;
endpackage

// File: design/peripheral_interrupt_sequencer.sv
// Interrupt flags, enables, vectoring and wake-up for the internal peripheral sources
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Function
// - serial flag set on byte, match, timeout
// - vector needs all enables, flag, stack room
// - serial service clears flag and global enable
// - UART events make a low request pulse
// - UART routed through shared vector enables
// - UART service clears shared flag only
// - low voltage sets flag, service clears
// - EEPROM write done sets flag, service clears
// - each timer has match A and P flags
// - timer one routed through shared vector
// - timer one service clears shared flag only
// - timer zero, periodic own vectors, auto clear
// - any rising flag wakes sleep mode
// - set flag holds until serviced or cleared
// - disabled enable blocks service, keeps flag
// - only program counter is pushed
// - interrupt return restores global enable
// - plain return leaves global enable cleared
// - grouped source sets shared flag
module peripheral_interrupt_sequencer (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [irq_seq_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [irq_seq_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [irq_seq_pkg::DATA_W-1:0] bus_rdata,
  input wire irq_seq_pkg::serial_events_t serial_events,
  input wire irq_seq_pkg::uart_events_t uart_events,
  input wire logic low_voltage_detect,
  input wire logic eeprom_write_done,
  input wire irq_seq_pkg::timer_events_t timer_events,
  input wire irq_seq_pkg::core_ctl_t core_ctl,
  input wire logic [irq_seq_pkg::PC_W-1:0] core_pc,
  output logic vector_call,
  output logic [irq_seq_pkg::VEC_W-1:0] vector_index,
  output logic stack_push,
  output logic [irq_seq_pkg::PC_W-1:0] stack_push_pc,
  output logic return_pop,
  output logic wake_up,
  output logic global_irq_enable
);

  function automatic logic [irq_seq_pkg::VEC_W-1:0] lowest_index(
    input logic [irq_seq_pkg::NUM_VECTORS-1:0] v
  );
    logic [irq_seq_pkg::VEC_W-1:0] r;
    r = irq_seq_pkg::VEC_RESET;
    for (int i = irq_seq_pkg::NUM_VECTORS - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = i[irq_seq_pkg::VEC_W-1:0];
      end
    end
    return r;
  endfunction

  logic [irq_seq_pkg::NUM_FLAGS-1:0] flags_reg;
  logic [irq_seq_pkg::NUM_FLAGS-1:0] flags_next;
  logic [irq_seq_pkg::NUM_FLAGS-1:0] flags_prev_reg;
  logic [irq_seq_pkg::NUM_FLAGS-1:0] enable_reg;
  logic [irq_seq_pkg::NUM_FLAGS-1:0] hw_set;
  logic [irq_seq_pkg::NUM_FLAGS-1:0] svc_clr;
  logic [irq_seq_pkg::NUM_VECTORS-1:0] req_vec;
  logic [irq_seq_pkg::VEC_W-1:0] take_vec;
  logic [irq_seq_pkg::VEC_W-1:0] last_vec_reg;
  logic ge_reg;
  logic ge_next;
  logic shared_en_reg;
  logic uart_pulse_n_reg;
  logic take;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_flags;
  logic vector_call_reg;
  logic [irq_seq_pkg::VEC_W-1:0] vector_index_reg;
  logic stack_push_reg;
  logic [irq_seq_pkg::PC_W-1:0] stack_push_pc_reg;
  logic return_pop_reg;
  logic wake_reg;
  logic [irq_seq_pkg::DATA_W-1:0] rdata_reg;

  assign wr_ctrl = bus_write && (bus_addr == irq_seq_pkg::OFS_CTRL);
  assign wr_enable = bus_write && (bus_addr == irq_seq_pkg::OFS_ENABLE);
  assign wr_flags = bus_write && (bus_addr == irq_seq_pkg::OFS_FLAGS);

  // Any UART condition pulls the request line low one cycle later, for as many cycles as it lasts
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      uart_pulse_n_reg <= 1'b1;
    end else begin
      uart_pulse_n_reg <= ~(|uart_events);
    end
  end

  // Hardware set events for every flag
  always_comb begin
    hw_set = '0;
    hw_set[irq_seq_pkg::F_SERIAL] = |serial_events;
    hw_set[irq_seq_pkg::F_LV] = low_voltage_detect;
    hw_set[irq_seq_pkg::F_EEPROM] = eeprom_write_done;
    hw_set[irq_seq_pkg::F_T0A] = timer_events.t0_match_a;
    hw_set[irq_seq_pkg::F_T0P] = timer_events.t0_match_p;
    hw_set[irq_seq_pkg::F_PTA] = timer_events.pt_match_a;
    hw_set[irq_seq_pkg::F_PTP] = timer_events.pt_match_p;
    hw_set[irq_seq_pkg::F_UART] = ~uart_pulse_n_reg;
    hw_set[irq_seq_pkg::F_T1A] = timer_events.t1_match_a;
    hw_set[irq_seq_pkg::F_T1P] = timer_events.t1_match_p;
    hw_set[irq_seq_pkg::F_SHARED] = hw_set[irq_seq_pkg::F_UART]
      | hw_set[irq_seq_pkg::F_T1A] | hw_set[irq_seq_pkg::F_T1P];
  end

  // Pending requests per vector; the shared vector also needs a source enable
  always_comb begin
    req_vec = '0;
    for (int i = 0; i < irq_seq_pkg::F_SHARED; i++) begin
      req_vec[i] = flags_reg[i] && enable_reg[i];
    end
    req_vec[irq_seq_pkg::F_SHARED] = flags_reg[irq_seq_pkg::F_SHARED] && shared_en_reg
      && ((flags_reg[irq_seq_pkg::F_UART] && enable_reg[irq_seq_pkg::F_UART])
      || (flags_reg[irq_seq_pkg::F_T1A] && enable_reg[irq_seq_pkg::F_T1A])
      || (flags_reg[irq_seq_pkg::F_T1P] && enable_reg[irq_seq_pkg::F_T1P]));
  end

  assign take = ge_reg && (|req_vec) && !core_ctl.stack_full;
  assign take_vec = lowest_index(req_vec);

  // Service clears only the flag that owns the vector; grouped flags stay
  always_comb begin
    svc_clr = '0;
    if (take) begin
      svc_clr[take_vec] = 1'b1;
    end
  end

  // A hardware set in the same cycle beats a service clear or a software write
  always_comb begin
    if (wr_flags) begin
      flags_next = bus_wdata[irq_seq_pkg::NUM_FLAGS-1:0] | hw_set;
    end else begin
      flags_next = (flags_reg & ~svc_clr) | hw_set;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags_reg <= irq_seq_pkg::FLAGS_RESET;
      flags_prev_reg <= irq_seq_pkg::FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
      flags_prev_reg <= flags_reg;
    end
  end

  // Return-from-interrupt re-arms; a plain return leaves the enable alone
  always_comb begin
    ge_next = ge_reg;
    if (take) begin
      ge_next = 1'b0;
    end
    if (wr_ctrl) begin
      ge_next = bus_wdata[irq_seq_pkg::CTRL_GLOBAL_BIT];
    end
    if (core_ctl.return_from_interrupt_op) begin
      ge_next = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ge_reg <= 1'b0;
      shared_en_reg <= 1'b0;
    end else begin
      ge_reg <= ge_next;
      if (wr_ctrl) begin
        shared_en_reg <= bus_wdata[irq_seq_pkg::CTRL_SHARED_BIT];
      end
    end
  end

  // Clearing an enable never touches a pending flag
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      enable_reg <= irq_seq_pkg::ENABLE_RESET;
    end else if (wr_enable) begin
      enable_reg <= bus_wdata[irq_seq_pkg::NUM_FLAGS-1:0];
    end
  end

  // Call sequence: only the program counter goes to the stack
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      vector_call_reg <= 1'b0;
      vector_index_reg <= irq_seq_pkg::VEC_RESET;
      stack_push_reg <= 1'b0;
      stack_push_pc_reg <= irq_seq_pkg::PC_RESET;
      last_vec_reg <= irq_seq_pkg::VEC_RESET;
      return_pop_reg <= 1'b0;
    end else begin
      vector_call_reg <= take;
      stack_push_reg <= take;
      return_pop_reg <= core_ctl.return_from_interrupt_op || core_ctl.plain_return_op;
      if (take) begin
        vector_index_reg <= take_vec;
        last_vec_reg <= take_vec;
        stack_push_pc_reg <= core_pc;
      end
    end
  end

  // Wake on any rising flag regardless of enables; a flag already high cannot rise
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wake_reg <= 1'b0;
    end else begin
      wake_reg <= core_ctl.sleep_mode && (|(flags_reg & ~flags_prev_reg));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rdata_reg <= irq_seq_pkg::RDATA_RESET;
    end else if (bus_read) begin
      rdata_reg <= irq_seq_pkg::RDATA_RESET;
      case (bus_addr)
        irq_seq_pkg::OFS_CTRL: begin
          rdata_reg[irq_seq_pkg::CTRL_GLOBAL_BIT] <= ge_reg;
          rdata_reg[irq_seq_pkg::CTRL_SHARED_BIT] <= shared_en_reg;
        end
        irq_seq_pkg::OFS_ENABLE: begin
          rdata_reg[irq_seq_pkg::NUM_FLAGS-1:0] <= enable_reg;
        end
        irq_seq_pkg::OFS_FLAGS: begin
          rdata_reg[irq_seq_pkg::NUM_FLAGS-1:0] <= flags_reg;
        end
        irq_seq_pkg::OFS_STATUS: begin
          rdata_reg[irq_seq_pkg::STAT_VEC_LSB +: irq_seq_pkg::VEC_W] <= last_vec_reg;
          rdata_reg[irq_seq_pkg::STAT_WAKE_BIT] <= wake_reg;
        end
        default: begin
          rdata_reg <= irq_seq_pkg::RDATA_RESET;
        end
      endcase
    end else begin
      rdata_reg <= irq_seq_pkg::RDATA_RESET;
    end
  end

  assign bus_rdata = rdata_reg;
  assign vector_call = vector_call_reg;
  assign vector_index = vector_index_reg;
  assign stack_push = stack_push_reg;
  assign stack_push_pc = stack_push_pc_reg;
  assign return_pop = return_pop_reg;
  assign wake_up = wake_reg;
  assign global_irq_enable = ge_reg;

  chk_call_needs_room: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    vector_call_reg |-> $past(ge_reg) && !$past(core_ctl.stack_full)
  ) else $error("Call taken without global enable or stack room");

  chk_call_clears_ge: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    take && !wr_ctrl && !core_ctl.return_from_interrupt_op |=> !ge_reg && vector_call_reg
  ) else $error("Global enable still set after a call");

  chk_serial_flag_set: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (|serial_events) |=> flags_reg[irq_seq_pkg::F_SERIAL]
  ) else $error("Serial event did not set its flag");

  chk_uart_low_pulse: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (|uart_events) |=> !uart_pulse_n_reg ##1
      (flags_reg[irq_seq_pkg::F_UART] && flags_reg[irq_seq_pkg::F_SHARED])
  ) else $error("UART event did not raise its flags");

  chk_grouped_flag_kept: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    take && take_vec == irq_seq_pkg::VEC_W'(irq_seq_pkg::F_SHARED) && !wr_flags
      && flags_reg[irq_seq_pkg::F_UART] |=> flags_reg[irq_seq_pkg::F_UART]
  ) else $error("Shared vector service cleared the UART flag");

  chk_flag_holds: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !take && !wr_flags |=> (flags_reg & $past(flags_reg)) == $past(flags_reg)
  ) else $error("Request flag dropped without service or write");

  chk_own_flag_cleared: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    take && !wr_flags && !hw_set[take_vec] |=> !flags_reg[$past(take_vec)]
  ) else $error("Serviced flag was not cleared");

  chk_push_pc: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    vector_call_reg |-> stack_push_reg && stack_push_pc_reg == $past(core_pc)
  ) else $error("Pushed value is not the program counter");

  chk_return_from_interrupt_op_sets_ge: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    core_ctl.return_from_interrupt_op |=> ge_reg && return_pop_reg
  ) else $error("Interrupt return did not restore global enable");

  chk_ret_keeps_ge: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    core_ctl.plain_return_op && !core_ctl.return_from_interrupt_op && !ge_reg && !wr_ctrl
      |=> !ge_reg && return_pop_reg
  ) else $error("Plain return changed global enable");

  chk_wake_on_rise: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    core_ctl.sleep_mode && (|(flags_reg & ~flags_prev_reg)) |=> wake_reg
  ) else $error("Rising flag did not wake the device");

  chk_lowest_first: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    vector_call_reg |-> vector_index_reg == lowest_index($past(req_vec))
  ) else $error("Vector chosen out of priority order");

  chk_shared_needs_en: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    vector_call_reg && vector_index_reg == irq_seq_pkg::VEC_W'(irq_seq_pkg::F_SHARED)
      |-> $past(shared_en_reg)
      && $past(|(enable_reg[irq_seq_pkg::F_T1P:irq_seq_pkg::F_UART]
      & flags_reg[irq_seq_pkg::F_T1P:irq_seq_pkg::F_UART]))
  ) else $error("Shared vector taken without its enables");

  chk_lv_flag_set: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    low_voltage_detect |=> flags_reg[irq_seq_pkg::F_LV]
  ) else $error("Low voltage did not set its flag");

  chk_eeprom_flag_set: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    eeprom_write_done |=> flags_reg[irq_seq_pkg::F_EEPROM]
  ) else $error("Write completion did not set its flag");

  chk_t0_match_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    timer_events.t0_match_a |=> flags_reg[irq_seq_pkg::F_T0A]
  ) else $error("Timer zero match A did not set its flag");

  chk_pt_match_p: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    timer_events.pt_match_p |=> flags_reg[irq_seq_pkg::F_PTP]
  ) else $error("Periodic timer match P did not set its flag");

  chk_t1_shared_set: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    timer_events.t1_match_a || timer_events.t1_match_p |=> flags_reg[irq_seq_pkg::F_SHARED]
  ) else $error("Timer one match did not set the shared flag");

  chk_disabled_kept: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    flags_reg[irq_seq_pkg::F_LV] && !enable_reg[irq_seq_pkg::F_LV] && !wr_flags
      |=> !(vector_call_reg && vector_index_reg == irq_seq_pkg::VEC_W'(irq_seq_pkg::F_LV))
      && flags_reg[irq_seq_pkg::F_LV]
  ) else $error("Disabled request was served or dropped");

  chk_timer_one_kept: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    take && take_vec == irq_seq_pkg::VEC_W'(irq_seq_pkg::F_SHARED) && !wr_flags
      && flags_reg[irq_seq_pkg::F_T1A] |=> flags_reg[irq_seq_pkg::F_T1A]
  ) else $error("Shared vector service cleared the timer one flag");

  chk_wake_needs_rise: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    wake_reg |-> $past(core_ctl.sleep_mode) && $past(|(flags_reg & ~flags_prev_reg))
  ) else $error("Wake raised without a rising flag");

endmodule

`default_nettype wire

// File: tb/core_seq_model.sv
// Behavioural model of the processor core sequencer facing the interrupt block
`timescale 1ns/1ps
`default_nettype none

module core_seq_model #(
  parameter int DEPTH = 4
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic stack_push,
  input wire logic ret_req,
  input wire logic plain_req,
  input wire logic full_req,
  input wire logic sleep_req,
  output irq_seq_pkg::core_ctl_t core_ctl
);
  int depth_reg;

  // One stack entry per call: only the program counter is saved
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      depth_reg <= 0;
    end else begin
      depth_reg <= depth_reg + int'(stack_push) - int'(ret_req | plain_req);
    end
  end

  // Stack counts as full at its depth; handlers never nest calls
  always_comb begin
    core_ctl.stack_full = full_req || (depth_reg >= DEPTH);
    core_ctl.return_from_interrupt_op = ret_req;
    core_ctl.plain_return_op = plain_req;
    core_ctl.sleep_mode = sleep_req;
  end
endmodule

`default_nettype wire

// File: tb/tb.sv
// Self-checking testbench for the peripheral interrupt sequencer
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] bus_addr = 8'h00;
  logic [31:0] bus_wdata = 32'h0, bus_rdata;
  logic bus_write = 1'b0, bus_read = 1'b0;
  logic [17:0] ev = 18'h0;
  logic [12:0] core_pc = 13'h0000, stack_push_pc, prev_pc = 13'h0000;
  logic vector_call, stack_push, return_pop, wake_up, global_irq_enable;
  logic [2:0] vector_index;
  logic ret_req = 1'b0, plain_req = 1'b0, full_req = 1'b0, sleep_req = 1'b0, rd_seen = 1'b0;
  logic pop_exp = 1'b0;
  irq_seq_pkg::core_ctl_t core_ctl;
  logic [31:0] exp_rd[$];
  logic [2:0] exp_vec[$];
  int mismatches = 0, cmp_count = 0, wake_cnt = 0;
  logic [10:0] ev_flags[18] = '{11'h001, 11'h001, 11'h001, 11'h001, 11'h180, 11'h180, 11'h180,
    11'h180, 11'h180, 11'h180, 11'h040, 11'h020, 11'h480, 11'h280, 11'h010, 11'h008, 11'h002,
    11'h004};

  always #50 clk_sys = ~clk_sys;

  peripheral_interrupt_sequencer i_peripheral_interrupt_sequencer (
    .clk_sys(clk_sys), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .serial_events(ev[3:0]), .uart_events(ev[9:4]), .low_voltage_detect(ev[16]),
    .eeprom_write_done(ev[17]), .timer_events(ev[15:10]), .core_ctl(core_ctl),
    .core_pc(core_pc), .vector_call(vector_call), .vector_index(vector_index),
    .stack_push(stack_push), .stack_push_pc(stack_push_pc), .return_pop(return_pop),
    .wake_up(wake_up), .global_irq_enable(global_irq_enable));

  core_seq_model i_core_seq_model (
    .clk_sys(clk_sys), .rstn(rstn), .stack_push(stack_push), .ret_req(ret_req),
    .plain_req(plain_req), .full_req(full_req), .sleep_req(sleep_req), .core_ctl(core_ctl));

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk_sys);
    bus_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    bus_addr <= a;
    bus_read <= 1'b1;
    exp_rd.push_back(d);
    @(posedge clk_sys);
    bus_read <= 1'b0;
  endtask

  // Pulses one cycle on the chosen source or core request lines
  task automatic pulse(input logic [17:0] e, input logic r, input logic p);
    @(posedge clk_sys);
    ev <= e;
    ret_req <= r;
    plain_req <= p;
    @(posedge clk_sys);
    ev <= 18'h0;
    ret_req <= 1'b0;
    plain_req <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask

  task automatic wait_calls();
    for (int n = 0; n < 30 && exp_vec.size() != 0; n++) @(posedge clk_sys);
    if (exp_vec.size() != 0) begin
      mismatches++;
      finish_test();
    end
  endtask

  // Monitor: results are taken from the outputs and matched against the oldest note
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      if (exp_rd.size() == 0) check(bus_rdata, 32'hFFFFFFFF);
      else check(bus_rdata, exp_rd.pop_front());
    end
    if (vector_call) begin
      if (exp_vec.size() == 0) check({29'h0, vector_index}, 32'hFFFFFFFF);
      else check({29'h0, vector_index}, {29'h0, exp_vec.pop_front()});
      check({19'h0, stack_push_pc}, {19'h0, prev_pc});
      check({31'h0, stack_push}, 32'h1);
      check({31'h0, global_irq_enable}, 32'h0);
    end
    // A return pops one cycle after the core asks for it
    if (rstn) check({31'h0, return_pop}, {31'h0, pop_exp});
    pop_exp = ret_req | plain_req;
    if (wake_up === 1'b1) wake_cnt++;
    prev_pc = core_pc;
    rd_seen = bus_read;
  end

  always @(posedge clk_sys) core_pc <= 13'($urandom);

  initial begin
    void'($urandom(32'hA1E92E7F));
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    exp_rd.delete();
    rd(8'h00, 0); rd(8'h04, 0); rd(8'h08, 0); rd(8'h0C, 0); rd(8'h10, 0);
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10, 0);
    $display("test registers done");
    for (int j = 0; j < 18; j++) begin
      pulse(18'h1 << j, 1'b0, 1'b0);
      rd(8'h08, {21'h0, ev_flags[j]});
      wr(8'h08, 0);
    end
    $display("test sources done");
    wr(8'h04, 32'h77F);
    pulse(18'h38400, 1'b0, 1'b0);
    exp_vec.push_back(3'h1);
    wr(8'h00, 32'h1);
    wait_calls();
    rd(8'h08, 32'h4C);
    rd(8'h00, 32'h0);
    for (int k = 0; k < 3; k++) begin
      exp_vec.push_back(k == 0 ? 3'h2 : (k == 1 ? 3'h3 : 3'h6));
      pulse(18'h0, 1'b1, 1'b0);
      wait_calls();
    end
    pulse(18'h0, 1'b0, 1'b1);
    rd(8'h00, 32'h0);
    rd(8'h08, 32'h0);
    $display("test priority done");
    wr(8'h00, 32'h2);
    pulse(18'h00010, 1'b0, 1'b0);
    rd(8'h08, 32'h180);
    exp_vec.push_back(3'h7);
    wr(8'h00, 32'h3);
    wait_calls();
    rd(8'h08, 32'h100);
    wr(8'h08, 0);
    pulse(18'h02000, 1'b0, 1'b0);
    exp_vec.push_back(3'h7);
    pulse(18'h0, 1'b1, 1'b0);
    wait_calls();
    rd(8'h08, 32'h200);
    wr(8'h08, 0);
    pulse(18'h0, 1'b0, 1'b1);
    $display("test shared vector done");
    wr(8'h04, 0);
    pulse(18'h10000, 1'b0, 1'b0);
    wr(8'h00, 32'h3);
    repeat (5) @(posedge clk_sys);
    rd(8'h08, 32'h002);
    full_req <= 1'b1;
    wr(8'h04, 32'h002);
    repeat (5) @(posedge clk_sys);
    exp_vec.push_back(3'h1);
    full_req <= 1'b0;
    wait_calls();
    rd(8'h08, 0);
    rd(8'h0C, 32'h1);
    wr(8'h04, 32'h001);
    pulse(18'h00004, 1'b0, 1'b0);
    exp_vec.push_back(3'h0);
    pulse(18'h0, 1'b1, 1'b0);
    wait_calls();
    rd(8'h08, 0);
    rd(8'h00, 32'h2);
    $display("test blocking done");
    sleep_req <= 1'b1;
    pulse(18'h20000, 1'b0, 1'b0);
    check(wake_cnt, 1);
    pulse(18'h20000, 1'b0, 1'b0);
    check(wake_cnt, 1);
    $display("test wake done");
    finish_test();
  end
endmodule

`default_nettype wire
